// ### pkg/aof_pkg.sv
// Purpose: Constants and gain table for the output formatting block
// Assumes: 12-bit samples, serial link of one lane
// Notes:   Shared by the formatter and its assertions
// Summary of operation
// - Coefficient pair selects gain; 111/110 is unity
// - Overload recovery mode defaults coefficients 001/111
// - Control write-only at 16h, readback at 17h
// - Bit 4 switches the equalizer on
// - Bit 3 picks two's complement or offset
// - Bit 2 picks LSB or MSB first
// - Select 00 sends converted samples
// - Select 01/10 send the two fixed words
// - Select 11 sends the custom word
// - Training word repeats every word
// - Bit and word clocks ignore training select
package aof_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h16;
  localparam logic [7:0] ADDR_RBACK  = 8'h17;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         BIT_EQ      = 4;
  localparam int         BIT_FMT     = 3;
  localparam int         BIT_MSB     = 2;
  localparam int         TRAIN_LO    = 0;
  localparam int         TRAIN_HI    = 1;

  // ----------------------------------------
  // Link and words
  // ----------------------------------------
  localparam int          WORD_BITS  = 12;
  localparam int          FIFO_DEPTH = 8;
  localparam logic [3:0]  BIT_LAST   = 4'hb;
  localparam logic [3:0]  BIT_HALF   = 4'h6;
  localparam logic [11:0] TRAIN_ONE  = 12'h03f;
  localparam logic [11:0] TRAIN_TWO  = 12'haaa;
  localparam logic [11:0] SAT_POS    = 12'h7ff;
  localparam logic [11:0] SAT_NEG    = 12'h800;
  localparam logic [1:0]  STRAP_WAIT = 2'h3;

  // ----------------------------------------
  // Gain
  // ----------------------------------------
  localparam int          GAIN_FRAC  = 10;
  localparam logic [10:0] GAIN_UNITY = 11'h400;
  localparam logic [2:0]  ADC_DEF_A  = 3'h7;
  localparam logic [2:0]  ADC_DEF_B  = 3'h6;
  localparam logic [2:0]  OVR_DEF_A  = 3'h1;
  localparam logic [2:0]  OVR_DEF_B  = 3'h7;

  typedef enum logic [1:0] {TS_SAMPLE, TS_FIXED1, TS_FIXED2, TS_CUSTOM} aof_train_e;

  // Multiplier in 1/1024 steps; unlisted pairs fall back to unity
  function automatic logic [10:0] aof_gain_mult(input logic [5:0] ab);
    logic [10:0] m;
    m = GAIN_UNITY;
    unique case (ab)
      6'h12, 6'h13: m = 11'h675;
      6'h11: m = 11'h64e;
      6'h10: m = 11'h627;
      6'h17: m = 11'h600;
      6'h16: m = 11'h5d8;
      6'h09: m = 11'h5b0;
      6'h08: m = 11'h589;
      6'h0f: m = 11'h562;
      6'h0e: m = 11'h53b;
      6'h01: m = 11'h514;
      6'h00: m = 11'h4ec;
      6'h07: m = 11'h4c5;
      6'h06: m = 11'h49d;
      6'h39: m = 11'h476;
      6'h38: m = 11'h44e;
      6'h3f: m = 11'h428;
      6'h3e: m = 11'h400;
      6'h31: m = 11'h3d9;
      6'h30: m = 11'h3b1;
      6'h37: m = 11'h389;
      6'h36: m = 11'h363;
      default: m = GAIN_UNITY;
    endcase
    return m;
  endfunction

endpackage

// ### src/aof_fifo.sv
// Purpose: Sample FIFO with a registered head word
// Assumes: DEPTH is a power of two
// Notes:   Head register adds one slot beyond DEPTH
module aof_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             load;

  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign load       = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (load) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Head word lives in a register so readers see stable data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_ff[rd_ff];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule

// ### src/aof_formatter.sv
// Purpose: Gain, format, training select and serializer for one lane
// Assumes: BIT_CLK_I comes from outside and is far slower than CLK_I
// Notes:   Samples and register port share CLK_I
module aof_formatter
  import aof_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic        GAIN_WR_I,
  input  wire logic [2:0]  GAIN_COEF_A_I,
  input  wire logic [2:0]  GAIN_COEF_B_I,
  input  wire logic        OVERLOAD_RECOVERY_MODE_I,
  input  wire logic [11:0] CUSTOM_WORD_I,
  input  wire logic        SAMPLE_VALID_I,
  input  wire logic [11:0] SAMPLE_I,
  output logic             SAMPLE_READY_O,
  input  wire logic        BIT_CLK_I,
  output logic             BIT_CLK_O,
  output logic             WORD_CLK_O,
  output logic             SER_DATA_O,
  output logic             EQUALIZER_ON_O
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic        [7:0]  ctrl_ff;
  logic        [2:0]  coef_a_ff;
  logic        [2:0]  coef_b_ff;
  logic        [10:0] gain_mult_ff;
  logic        [1:0]  strap_cnt_ff;
  logic               ovr_s1_ff;
  logic               ovr_s2_ff;
  logic               strap_ld;
  logic               bclk_s1_ff;
  logic               bclk_s2_ff;
  logic               bclk_s3_ff;
  logic               bit_edge;
  logic               boundary;
  logic        [3:0]  bit_cnt_ff;
  logic        [11:0] word_ff;
  logic               msb_first_ff;
  logic               fmt_ff;
  aof_train_e         train_ff;
  aof_train_e         nxt_train;
  logic        [11:0] nxt_word;
  logic signed [23:0] prod;
  logic        [11:0] gained;
  logic        [11:0] stage_ff;
  logic               stage_vld_ff;
  logic               nxt_stage_vld;
  logic               accept;
  logic               fifo_in_rdy;
  logic               fifo_out_vld;
  logic        [11:0] fifo_out_data;
  logic               fifo_pop;
  logic               ctrl_wr;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  assign ctrl_wr = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);

  // Reserved bits are kept so the readback is exact
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= REG_WDATA_I;
    end
  end

  // Write-only address reads zero; readback stands until the next read
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= '0;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= (REG_ADDR_I == ADDR_RBACK) ? ctrl_ff : '0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      EQUALIZER_ON_O <= 1'b0;
    end else begin
      EQUALIZER_ON_O <= ctrl_wr ? REG_WDATA_I[BIT_EQ] : ctrl_ff[BIT_EQ];
    end
  end

  // ----------------------------------------
  // Gain coefficients
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovr_s1_ff <= 1'b0;
      ovr_s2_ff <= 1'b0;
    end else begin
      ovr_s1_ff <= OVERLOAD_RECOVERY_MODE_I;
      ovr_s2_ff <= ovr_s1_ff;
    end
  end

  // Strap read once the synchroniser has settled after reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt_ff <= '0;
    end else if (strap_cnt_ff != STRAP_WAIT) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
    end
  end

  assign strap_ld = (strap_cnt_ff == (STRAP_WAIT - 2'h1));

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      coef_a_ff <= ADC_DEF_A;
      coef_b_ff <= ADC_DEF_B;
    end else if (GAIN_WR_I) begin
      coef_a_ff <= GAIN_COEF_A_I;
      coef_b_ff <= GAIN_COEF_B_I;
    end else if (strap_ld && ovr_s2_ff) begin
      coef_a_ff <= OVR_DEF_A;
      coef_b_ff <= OVR_DEF_B;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gain_mult_ff <= GAIN_UNITY;
    end else begin
      gain_mult_ff <= aof_gain_mult({coef_a_ff, coef_b_ff});
    end
  end

  // ----------------------------------------
  // Gain stage
  // ----------------------------------------
  // Worst case 2048 x 1653 fits in 23 bits, so no product overflow
  assign prod = $signed(SAMPLE_I) * $signed({1'b0, gain_mult_ff});

  always_comb begin
    if (prod[23:21] == 3'h0 || prod[23:21] == 3'h7) begin
      gained = prod[21:10];
    end else if (prod[23]) begin
      gained = SAT_NEG;
    end else begin
      gained = SAT_POS;
    end
  end

  assign accept = SAMPLE_VALID_I && SAMPLE_READY_O;

  always_comb begin
    nxt_stage_vld = stage_vld_ff;
    if (accept) begin
      nxt_stage_vld = 1'b1;
    end else if (stage_vld_ff && fifo_in_rdy) begin
      nxt_stage_vld = 1'b0;
    end
  end

  // Half rate at the input is ample: words leave once per twelve bits
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stage_vld_ff   <= 1'b0;
      stage_ff       <= '0;
      SAMPLE_READY_O <= 1'b0;
    end else begin
      stage_vld_ff   <= nxt_stage_vld;
      SAMPLE_READY_O <= !nxt_stage_vld;
      if (accept) begin
        stage_ff <= gained;
      end
    end
  end

  aof_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (stage_vld_ff),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (stage_ff),
    .out_valid_o (fifo_out_vld),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------
  // Bit clock sampling
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bclk_s1_ff <= 1'b0;
      bclk_s2_ff <= 1'b0;
      bclk_s3_ff <= 1'b0;
    end else begin
      bclk_s1_ff <= BIT_CLK_I;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_s3_ff <= bclk_s2_ff;
    end
  end

  assign bit_edge = bclk_s2_ff && !bclk_s3_ff;
  assign boundary = bit_edge && (bit_cnt_ff == BIT_LAST);

  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  assign nxt_train = aof_train_e'(ctrl_ff[TRAIN_HI:TRAIN_LO]);
  // In training the FIFO is left alone so the source is held back
  assign fifo_pop = boundary && (nxt_train == TS_SAMPLE);

  // Underrun sends zero rather than a stale sample
  always_comb begin
    nxt_word = '0;
    unique case (nxt_train)
      TS_SAMPLE: begin
        if (fifo_out_vld) begin
          nxt_word = fifo_out_data;
          if (ctrl_ff[BIT_FMT]) begin
            nxt_word[11] = ~fifo_out_data[11];
          end
        end
      end
      TS_FIXED1: nxt_word = TRAIN_ONE;
      TS_FIXED2: nxt_word = TRAIN_TWO;
      TS_CUSTOM: nxt_word = CUSTOM_WORD_I;
    endcase
  end

  // Settings are sampled only as a new word starts
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      train_ff     <= TS_SAMPLE;
      fmt_ff       <= 1'b0;
      msb_first_ff <= 1'b0;
    end else if (boundary) begin
      train_ff     <= nxt_train;
      fmt_ff       <= ctrl_ff[BIT_FMT];
      msb_first_ff <= ctrl_ff[BIT_MSB];
    end
  end

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bit_cnt_ff <= BIT_LAST;
      word_ff    <= '0;
      SER_DATA_O <= 1'b0;
    end else if (boundary) begin
      bit_cnt_ff <= '0;
      word_ff    <= nxt_word;
      SER_DATA_O <= ctrl_ff[BIT_MSB] ? nxt_word[11] : nxt_word[0];
    end else if (bit_edge) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      SER_DATA_O <= msb_first_ff ? word_ff[BIT_LAST - bit_cnt_ff - 4'h1]
                                 : word_ff[bit_cnt_ff + 4'h1];
    end
  end

  // Word clock depends only on the bit counter, bit clock only on the sampled pin; neither on the word source
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WORD_CLK_O <= 1'b0;
      BIT_CLK_O  <= 1'b0;
    end else begin
      BIT_CLK_O <= bclk_s2_ff;
      if (boundary) begin
        WORD_CLK_O <= 1'b1;
      end else if (bit_edge && (bit_cnt_ff + 4'h1 == BIT_HALF)) begin
        WORD_CLK_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  chk_gain_unity: assert property (
    GAIN_WR_I && GAIN_COEF_A_I == ADC_DEF_A && GAIN_COEF_B_I == ADC_DEF_B
    |=> ##1 gain_mult_ff == GAIN_UNITY)
    else $error("unity coefficients did not give unity gain");

  chk_ovr_default: assert property (
    strap_ld && ovr_s2_ff && !GAIN_WR_I
    |=> coef_a_ff == OVR_DEF_A && coef_b_ff == OVR_DEF_B ##1 gain_mult_ff == 11'h562)
    else $error("overload recovery default gain wrong");

  chk_readback_value: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_RBACK |=> REG_RDATA_O == $past(ctrl_ff))
    else $error("readback differs from control register");

  chk_write_only: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_CTRL |=> REG_RDATA_O == 8'h00)
    else $error("write-only address returned data");

  chk_eq_follows: assert property (
    ctrl_wr |=> EQUALIZER_ON_O == $past(REG_WDATA_I[BIT_EQ]))
    else $error("equalizer enable does not follow write");

  chk_train_fixed: assert property (
    boundary && nxt_train == TS_FIXED1 |=> word_ff == TRAIN_ONE)
    else $error("fixed training word one not loaded");

  chk_train_custom: assert property (
    boundary && nxt_train == TS_CUSTOM |=> word_ff == $past(CUSTOM_WORD_I))
    else $error("custom training word not loaded");

  chk_sample_fmt: assert property (
    boundary && nxt_train == TS_SAMPLE && fifo_out_vld
    |=> word_ff == ($past(fifo_out_data) ^ {$past(ctrl_ff[BIT_FMT]), 11'h000}))
    else $error("sample word format wrong");

  chk_first_bit: assert property (
    boundary |=> SER_DATA_O == (msb_first_ff ? word_ff[11] : word_ff[0]))
    else $error("first serial bit in wrong order");

  chk_word_clock: assert property (
    boundary |=> WORD_CLK_O && bit_cnt_ff == 4'h0)
    else $error("word clock not raised at word start");

  chk_cfg_hold: assert property (
    !boundary |=> $stable(train_ff) && $stable(msb_first_ff) && $stable(fmt_ff))
    else $error("settings changed inside a word");

  cov_training: cover property (boundary && nxt_train == TS_FIXED2);
  cov_sample:   cover property (fifo_pop && fifo_out_vld);
  cov_readback: cover property (REG_RD_I && REG_ADDR_I == ADDR_RBACK ##1 REG_RDATA_O != 8'h00);
  cov_stall:    cover property (SAMPLE_VALID_I && !SAMPLE_READY_O && !fifo_in_rdy);

endmodule

// ### verif/aof_rx_model.sv
// Purpose: Capture model for the serial lane of the formatter
// Assumes: Bit clock is made here and runs free, as the device's clocks do
// Notes:   Words are kept in arrival order; the bench undoes the bit order
module aof_rx_model (
  input  wire logic slow_i,
  input  wire logic ser_i,
  input  wire logic wclk_i,
  output logic      bclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] words[$];
  logic [11:0] pats[$];
  logic [11:0] arr;
  logic [11:0] pat;
  logic        prev_w;
  int          idx;

  // ----------------------------------------
  // Bit clock, odd phase to stay off CLK_I edges
  // ----------------------------------------
  initial begin
    bclk_o = 1'b0;
    prev_w = 1'b0;
    idx = 12;
    #7;
    forever begin
      #(slow_i ? 400 : 200);
      bclk_o = ~bclk_o;
    end
  end

  // ----------------------------------------
  // Capture at the next rise, once the bit has settled
  // ----------------------------------------
  always @(posedge bclk_o) begin
    if (wclk_i && !prev_w) idx = 0;
    if (idx < 12) begin
      arr[idx] = ser_i;
      pat[idx] = wclk_i;
      idx++;
      if (idx == 12) begin
        words.push_back(arr);
        pats.push_back(pat);
      end
    end
    prev_w = wclk_i;
  end
endmodule

// ### verif/test_aof_formatter.sv
// Purpose: Self-checking bench for the output formatter
// Assumes: Gain multipliers in 1/1024 steps from the dB table
// Notes:   Serial words are checked through the capture model
module test_aof_formatter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, reg_wr, reg_rd, gain_wr, strap, s_valid;
  logic        s_ready, bclk, bclk_out, wclk, ser, eq, slow, last_msb;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
  logic [2:0]  coef_a, coef_b;
  logic [11:0] custom, s_data, last_w, w;
  int          error_cnt, n_tests, cyc;

  aof_formatter u_dut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
    .GAIN_WR_I(gain_wr), .GAIN_COEF_A_I(coef_a), .GAIN_COEF_B_I(coef_b),
    .OVERLOAD_RECOVERY_MODE_I(strap), .CUSTOM_WORD_I(custom), .SAMPLE_VALID_I(s_valid),
    .SAMPLE_I(s_data), .SAMPLE_READY_O(s_ready), .BIT_CLK_I(bclk), .BIT_CLK_O(bclk_out),
    .WORD_CLK_O(wclk), .SER_DATA_O(ser), .EQUALIZER_ON_O(eq));
  aof_rx_model u_rx (.slow_i(slow), .ser_i(ser), .wclk_i(wclk), .bclk_o(bclk));

  initial clk = 1'b0;
  always #25 clk = ~clk;
  // Whole run needs about 7000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Results truncate toward minus infinity and saturate at both ends
  function automatic logic [11:0] xf(input logic [11:0] s, input logic [10:0] m,
                                     input logic ob);
    logic signed [23:0] p;
    p = ($signed({{12{s[11]}}, s}) * $signed({13'h0, m})) >>> 10;
    if (p > 24'sh7ff) p = 24'sh7ff;
    if (p < -24'sh800) p = -24'sh800;
    return p[11:0] ^ {ob, 11'h000};
  endfunction
  function automatic logic [11:0] flip(input logic [11:0] a, input logic r);
    logic [11:0] b;
    for (int i = 0; i < 12; i++) b[i] = r ? a[11 - i] : a[i];
    return b;
  endfunction
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic gain_load(input logic [2:0] a, input logic [2:0] b);
    @(negedge clk);
    gain_wr = 1'b1;
    coef_a = a;
    coef_b = b;
    @(negedge clk);
    gain_wr = 1'b0;
  endtask
  task automatic do_reset(input logic st);
    strap = st;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic collect(input int n);
    int k;
    k = 0;
    while (u_rx.words.size() < n && k < 20000) begin
      @(negedge clk);
      k++;
    end
  endtask
  // First word may still be the old one, but only whole
  task automatic train(input logic [1:0] ts, input logic msb, input logic [11:0] e);
    reg_write(8'h16, {4'h0, 1'b1, msb, ts});
    u_rx.words.delete();
    u_rx.pats.delete();
    collect(4);
    // Copy of the bit clock lags the pin by three system clocks
    @(posedge bclk);
    repeat (3) @(negedge clk);
    check("bit clock high", 12'h001, {11'h0, bclk_out});
    @(negedge bclk);
    repeat (3) @(negedge clk);
    check("bit clock low", 12'h000, {11'h0, bclk_out});
    for (int i = 0; i < 4; i++) begin
      w = flip(u_rx.words[i], msb);
      if (i == 0 && flip(u_rx.words[0], last_msb) === last_w) w = e;
      check("training word", e, w);
      check("word clock", 12'h03f, u_rx.pats[i]);
    end
    last_w = e;
    last_msb = msb;
    $display("training select %0d order %0d done", ts, msb);
  endtask
  // Fill the buffer while training stalls it, then drain as samples
  task automatic stream(input logic [7:0] c, input logic [10:0] m);
    logic [11:0] q[$];
    logic [11:0] s;
    int          n;
    reg_write(8'h16, 8'h02);
    n = 0;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      if (s_ready) begin
        s = 12'($urandom);
        if (n == 0) s = 12'h7ff;
        if (n == 1) s = 12'h800;
        if (s[11]) s[10:9] = 2'h0;
        s_valid = 1'b1;
        s_data = s;
        q.push_back(s);
        n++;
        @(negedge clk);
        s_valid = 1'b0;
        s_data = ~s;
      end
    end
    check("samples held", 12'h00a, 12'(n));
    check("ready when full", 12'h000, {11'h0, s_ready});
    reg_write(8'h16, c);
    u_rx.words.delete();
    collect(14);
    n = 0;
    while (n < 3 && flip(u_rx.words[n], c[2]) !== xf(q[0], m, c[3])) n++;
    for (int i = 0; i < 10; i++) begin
      check("sample word", xf(q[i], m, c[3]), flip(u_rx.words[n + i], c[2]));
    end
    check("empty word", 12'h000, flip(u_rx.words[n + 10], c[2]));
    check("equalizer", {11'h0, c[4]}, {11'h0, eq});
    $display("sample stream %h done", c);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_wr, reg_rd, gain_wr, s_valid, slow, last_msb} = '0;
    {reg_addr, reg_wdata, coef_a, coef_b, custom, s_data, last_w} = '0;
    strap = 1'b0;
    rst = 1'b1;
    void'($urandom(32'he031));
    do_reset(1'b0);
    reg_read(8'h17, rd);
    check("reset readback", 12'h000, {4'h0, rd});
    for (int i = 0; i < 4; i++) begin
      w = 12'($urandom) & 12'h01f;
      reg_write(8'h16, w[7:0]);
      reg_read(8'h17, rd);
      check("readback", w, {4'h0, rd});
      check("equalizer", {11'h0, w[4]}, {11'h0, eq});
      reg_read(8'h16, rd);
      check("write-only read", 12'h000, {4'h0, rd});
    end
    reg_write(8'h18, 8'hff);
    reg_read(8'h17, rd);
    check("unmapped write", w, {4'h0, rd});
    reg_write(8'h16, 8'h00);
    $display("register tests done");
    custom = 12'($urandom);
    for (int i = 1; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        slow = (i == 3 && j == 1);
        train(2'(i), j[0], (i == 1) ? 12'h03f : (i == 2) ? 12'haaa : custom);
      end
    end
    slow = 1'b0;
    gain_load(3'h7, 3'h6);
    stream(8'h00, 11'h400);
    gain_load(3'h2, 3'h2);
    stream(8'h1c, 11'h675);
    do_reset(1'b1);
    stream(8'h08, 11'h562);
    close_out();
  end
endmodule
